// [host_lane_pkg.sv]
// Constants for the host byte-lane steering block.
// Assumes an APB register bus with 32-bit data and byte addressing.
package host_lane_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] OFS_EXCHANGE = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;

  // ****************************************
  // Values after reset and field positions
  // ****************************************
  localparam logic [31:0] EXCHANGE_ON = 32'hffffffff;
  localparam logic [31:0] EXCHANGE_RESET = 32'h00000000;
  localparam logic WIDE_RESET = 1'b1;
  localparam int ST_WIDE = 0;
  localparam int ST_EXCH = 1;
  localparam int ST_WR_PEND = 2;
  localparam int ST_RD_PEND = 3;
  localparam int ST_DROP_LSB = 8;
  localparam int DROP_W = 8;

  // ****************************************
  // Halfword pairing states
  // ****************************************
  typedef enum logic [1:0] {
    PAIR_IDLE = 2'b01,
    PAIR_HALF = 2'b10
  } pair_state_t;

endpackage

// [host_byte_lane_ordering.sv]
// Byte-lane steering between the host data bus and the internal 32-bit word.
// Assumes host strobes are one-cycle pulses synchronous to pclk, and that
// internal read data is valid in the same cycle as the read strobe.
//
// Our own choices: the placing of the registers and the APB register port.

// Overview of operation
// - Halfword exchange only acts in 16-bit mode.
// - 32-bit mode keeps upper and lower halfwords.
// - Placement uses strap, exchange, order select, A1.
// - Writes exchange then reorder; reads reverse.
// - Steering covers registers and all FIFOs.
// - Internal bytes numbered 3 down to 0.
// - 32-bit: select high reverses all four bytes.
// - 16-bit unexchanged halfword lane table.
// - 16-bit exchanged halfword lane table.
// - Select low little endian, high big endian.
// - Repeated halfword write discards the DWORD.
module host_byte_lane_ordering #(
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bus_width_strap,
  input wire logic byte_order_sel,
  input wire logic low_halfword_addr_line,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [31:0] host_wdata,
  output logic [31:0] host_rdata,
  output logic host_upper_oe,
  output logic int_wr,
  output logic [31:0] int_wdata,
  output logic int_rd,
  input wire logic [31:0] int_rdata
);
  import host_lane_pkg::*;

  // The status offset needs at least three address bits to decode
  if (ADDR_W < 3 || ADDR_W > 12) begin : g_addr_w_check
    $error("ADDR_W must lie between 3 and 12");
  end

  // ****************************************
  // Lane functions
  // ****************************************
  // Byte 3 is bits 31:24, byte 0 is bits 7:0
  function automatic logic [15:0] swap16(input logic [15:0] h);
    swap16 = {h[7:0], h[15:8]};
  endfunction

  function automatic logic [31:0] rev32(input logic [31:0] w);
    rev32 = {swap16(w[15:0]), swap16(w[31:16])};
  endfunction

  // ****************************************
  // State
  // ****************************************
  logic wide32;
  logic strap_taken;
  logic [31:0] exchange_reg;
  pair_state_t wr_state;
  pair_state_t rd_state;
  logic wr_first_hi;
  logic rd_first_hi;
  logic [15:0] wr_buf;
  logic [31:0] rd_buf;
  logic [DROP_W-1:0] drop_cnt;

  // ****************************************
  // Steering decode
  // ****************************************
  wire exch_active = !wide32 && (exchange_reg == EXCHANGE_ON);
  // Exchange flips A1 first, then big endian picks the opposite half
  wire hi_sel = (low_halfword_addr_line ^ exch_active) ^ byte_order_sel;
  wire [15:0] wr_half = byte_order_sel ? swap16(host_wdata[15:0]) : host_wdata[15:0];
  wire [31:0] wr_word32 = byte_order_sel ? rev32(host_wdata) : host_wdata;
  wire wr_pair_done = (wr_state == PAIR_HALF) && (hi_sel != wr_first_hi);
  wire wr_pair_drop = (wr_state == PAIR_HALF) && (hi_sel == wr_first_hi);
  // A repeated read half restarts with a fresh fetch, it is not fatal
  wire rd_fetch = wide32 || (rd_state == PAIR_IDLE) || (hi_sel == rd_first_hi);
  wire [31:0] rd_word = rd_fetch ? int_rdata : rd_buf;
  wire [15:0] rd_half = hi_sel ? rd_word[31:16] : rd_word[15:0];
  wire [15:0] rd_lane = byte_order_sel ? swap16(rd_half) : rd_half;
  wire [31:0] rd_word32 = byte_order_sel ? rev32(int_rdata) : int_rdata;

  // Same steering serves register and FIFO traffic alike
  assign int_rd = host_rd && rd_fetch;
  assign host_upper_oe = wide32;

  // ****************************************
  // Bus width strap capture
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wide32 <= WIDE_RESET;
      strap_taken <= 1'b0;
    end else if (!strap_taken) begin
      wide32 <= bus_width_strap;
      strap_taken <= 1'b1;
    end
  end

  // ****************************************
  // Host write path
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_state <= PAIR_IDLE;
      wr_first_hi <= 1'b0;
      wr_buf <= 16'h0000;
      int_wr <= 1'b0;
      int_wdata <= 32'h00000000;
      drop_cnt <= '0;
    end else begin
      int_wr <= 1'b0;
      if (host_wr && wide32) begin
        int_wdata <= wr_word32;
        int_wr <= 1'b1;
      end else if (host_wr) begin
        case (wr_state)
          PAIR_IDLE: begin
            wr_buf <= wr_half;
            wr_first_hi <= hi_sel;
            wr_state <= PAIR_HALF;
          end
          PAIR_HALF: begin
            wr_state <= PAIR_IDLE;
            if (wr_pair_done) begin
              int_wdata <= hi_sel ? {wr_half, wr_buf} : {wr_buf, wr_half};
              int_wr <= 1'b1;
            end else begin
              drop_cnt <= drop_cnt + 1'b1;
            end
          end
          default: wr_state <= PAIR_IDLE;
        endcase
      end
    end
  end

  // ****************************************
  // Host read path
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_state <= PAIR_IDLE;
      rd_first_hi <= 1'b0;
      rd_buf <= 32'h00000000;
      host_rdata <= 32'h00000000;
    end else if (host_rd && wide32) begin
      host_rdata <= rd_word32;
    end else if (host_rd) begin
      // Upper lanes are not driven in 16-bit mode
      host_rdata <= {16'h0000, rd_lane};
      case (rd_state)
        PAIR_IDLE, PAIR_HALF: begin
          if (rd_fetch) begin
            rd_buf <= int_rdata;
            rd_first_hi <= hi_sel;
            rd_state <= PAIR_HALF;
          end else begin
            rd_state <= PAIR_IDLE;
          end
        end
        default: rd_state <= PAIR_IDLE;
      endcase
    end
  end

  // ****************************************
  // APB slave
  // ****************************************
  wire setup_phase = psel && !penable;
  wire access_phase = psel && penable;
  wire hit_exchange = (paddr == ADDR_W'(OFS_EXCHANGE));
  wire hit_status = (paddr == ADDR_W'(OFS_STATUS));
  wire [31:0] status_word = {16'h0000, drop_cnt, 4'h0, rd_state == PAIR_HALF,
                             wr_state == PAIR_HALF, exch_active, wide32};
  wire [31:0] next_prdata = hit_exchange ? exchange_reg : (hit_status ? status_word : 32'h0);

  assign pready = 1'b1;
  assign pslverr = access_phase && !(hit_exchange || hit_status);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exchange_reg <= EXCHANGE_RESET;
      prdata <= 32'h00000000;
    end else begin
      if (setup_phase) begin
        prdata <= next_prdata;
      end
      if (access_phase && pwrite && hit_exchange) begin
        exchange_reg <= pwdata;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_exch_wide_ignored: assert property (
    @(posedge pclk) disable iff (!presetn) wide32 |-> !exch_active)
    else $error("exchange active in 32-bit mode");

  a_exch_exact_ones: assert property (
    @(posedge pclk) disable iff (!presetn) exch_active |-> exchange_reg == EXCHANGE_ON)
    else $error("exchange active without all-ones value");

  a_wide_straight: assert property (
    @(posedge pclk) disable iff (!presetn)
    host_wr && wide32 && !byte_order_sel |=> int_wr && int_wdata == $past(host_wdata))
    else $error("32-bit little endian write not straight");

  a_wide_reversed: assert property (
    @(posedge pclk) disable iff (!presetn)
    host_rd && wide32 && byte_order_sel |=>
    host_rdata[31:24] == $past(int_rdata[7:0]) && host_rdata[7:0] == $past(int_rdata[31:24]))
    else $error("32-bit big endian read not reversed");

  a_first_half_held: assert property (
    @(posedge pclk) disable iff (!presetn)
    host_wr && !wide32 && wr_state == PAIR_IDLE |=> !int_wr && wr_state == PAIR_HALF)
    else $error("first halfword wrote internally");

  a_pair_completes: assert property (
    @(posedge pclk) disable iff (!presetn)
    host_wr && !wide32 && wr_pair_done && !exch_active && !byte_order_sel
    && low_halfword_addr_line |=> int_wr && int_wdata[31:16] == $past(host_wdata[15:0]))
    else $error("upper halfword misplaced");

  a_same_half_drop: assert property (
    @(posedge pclk) disable iff (!presetn)
    host_wr && !wide32 && wr_pair_drop |=> !int_wr && wr_state == PAIR_IDLE)
    else $error("repeated halfword not discarded");

  a_read_plain_low: assert property (
    @(posedge pclk) disable iff (!presetn)
    host_rd && int_rd && !wide32 && !exch_active && !byte_order_sel && !low_halfword_addr_line
    |=> host_rdata[15:0] == $past(int_rdata[15:0]))
    else $error("unexchanged low read misplaced");

  a_read_exch_map: assert property (
    @(posedge pclk) disable iff (!presetn)
    host_rd && int_rd && !wide32 && exch_active && byte_order_sel && low_halfword_addr_line
    |=> host_rdata[15:8] == $past(int_rdata[23:16]) && host_rdata[7:0] == $past(int_rdata[31:24]))
    else $error("exchanged big endian read misplaced");

endmodule

// [host_cpu_model.sv]
// Host CPU model for the byte-lane steering block.
// Assumes the bench supplies pclk and calls the tasks.
module host_cpu_model (
  input wire logic pclk,
  output logic host_wr,
  output logic host_rd,
  output logic [31:0] host_wdata,
  output logic byte_order_sel,
  output logic low_halfword_addr_line,
  input wire logic [31:0] host_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // Host bus cycles
  // ****************
  initial begin
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_wdata = 32'h0;
    byte_order_sel = 1'b0;
    low_halfword_addr_line = 1'b0;
  end
  // Order select and A1 travel with the strobe
  task automatic hw(input logic s, input logic a, input logic [31:0] d);
    @(posedge pclk);
    host_wr <= 1'b1;
    host_wdata <= d;
    byte_order_sel <= s;
    low_halfword_addr_line <= a;
    @(posedge pclk);
    host_wr <= 1'b0;
    host_wdata <= ~d; // Released bus must not look valid
  endtask
  task automatic hr(input logic s, input logic a, output logic [31:0] q);
    @(posedge pclk);
    host_rd <= 1'b1;
    byte_order_sel <= s;
    low_halfword_addr_line <= a;
    @(posedge pclk);
    host_rd <= 1'b0;
    // Read data stands until the next read, so take it one edge later
    @(posedge pclk);
    q = host_rdata;
  endtask
endmodule

// [tb_host_byte_lane_ordering.sv]
// Bench for the host byte-lane steering block.
// Assumes the package, design and host_cpu_model are compiled first.
module tb_host_byte_lane_ordering;
  timeunit 1ns;
  timeprecision 1ps;
  import host_lane_pkg::*;
  // ****************
  // Signals
  // ****************
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, strap = 1, e;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 0, int_rdata = 0, q, w, xv, last_w = 0;
  logic [31:0] prdata, host_rdata, host_wdata, int_wdata;
  logic pready, pslverr, host_upper_oe, int_wr, int_rd, hwr, hrd, sel, a1;
  int n_errors = 0, total_checks = 0, cyc = 0, n_wr = 0, n_rd = 0, n;
  always #12.5 pclk = ~pclk;
  host_cpu_model i_host (.pclk(pclk), .host_wr(hwr), .host_rd(hrd),
    .host_wdata(host_wdata), .byte_order_sel(sel), .low_halfword_addr_line(a1),
    .host_rdata(host_rdata));
  host_byte_lane_ordering i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus_width_strap(strap), .byte_order_sel(sel), .low_halfword_addr_line(a1),
    .host_wr(hwr), .host_rd(hrd), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .host_upper_oe(host_upper_oe), .int_wr(int_wr),
    .int_wdata(int_wdata), .int_rd(int_rd), .int_rdata(int_rdata));
  always @(posedge pclk) begin
    if (int_wr === 1'b1) begin
      n_wr <= n_wr + 1;
      last_w <= int_wdata;
    end
    if (int_rd === 1'b1) n_rd <= n_rd + 1;
  end
  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      complete_run();
    end
  end
  // ****************
  // Tasks
  // ****************
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x) begin
      n_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // Waits as long as the slave asks; only the hang guard ends a stuck wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // Lane pair shown to the host; byte 3 is bits 31:24
  // Byte numbers on D[15:8] and D[7:0], written out from the lane tables
  function automatic logic [15:0] lane(input logic [31:0] v, input logic x, s, a);
    logic [3:0] p;
    case ({x, s, a})
      3'h1: p = 4'he;
      3'h0: p = 4'h4;
      3'h3: p = 4'h1;
      3'h2: p = 4'hb;
      3'h5: p = 4'h4;
      3'h4: p = 4'he;
      3'h7: p = 4'hb;
      default: p = 4'h1;
    endcase
    return {v[8 * p[3:2] +: 8], v[8 * p[1:0] +: 8]};
  endfunction
  function automatic logic [31:0] bsw(input logic [31:0] v);
    return {v[7:0], v[15:8], v[23:16], v[31:24]};
  endfunction
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ****************
  // Tests
  // ****************
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    repeat (2) @(posedge pclk);
    apb(0, OFS_EXCHANGE, 0);
    chk(q, EXCHANGE_RESET);
    apb(1, 12'h008, 32'h1234);
    chk({31'h0, e}, 32'h1);
    apb(1, OFS_EXCHANGE, EXCHANGE_ON);
    apb(0, OFS_STATUS, 0);
    chk({30'h0, q[1:0]}, 32'h1);
    chk({31'h0, host_upper_oe}, 32'h1);
    for (int s = 0; s < 2; s++) begin
      w = 32'h11223344 + s;
      i_host.hw(s[0], 0, w);
      repeat (2) @(posedge pclk);
      chk(last_w, s ? bsw(w) : w);
      int_rdata <= 32'ha1b2c3d4;
      i_host.hr(s[0], 1, q);
      chk(q, s ? 32'hd4c3b2a1 : 32'ha1b2c3d4);
    end
    $display("wide mode tests done");
    strap <= 0;
    presetn <= 0;
    repeat (20) @(posedge pclk);
    presetn <= 1;
    repeat (2) @(posedge pclk);
    chk({31'h0, host_upper_oe}, 32'h0);
    for (int i = 0; i < 12; i++) begin
      xv = (i < 4) ? 32'h0 : (i < 8) ? EXCHANGE_ON : 32'hfffffffe;
      w = 32'h9c4a1e07 + 32'h01030507 * i;
      apb(1, OFS_EXCHANGE, xv);
      apb(0, OFS_STATUS, 0);
      chk({31'h0, q[ST_EXCH]}, {31'h0, xv == EXCHANGE_ON});
      n = n_wr;
      i_host.hw(i[1], i[0], {16'h0, lane(w, xv == EXCHANGE_ON, i[1], i[0])});
      i_host.hw(i[1], !i[0], {16'h0, lane(w, xv == EXCHANGE_ON, i[1], !i[0])});
      repeat (2) @(posedge pclk);
      chk(n_wr - n, 32'h1);
      chk(last_w, w);
      int_rdata <= w;
      i_host.hr(i[1], i[0], q);
      chk(q, {16'h0, lane(w, xv == EXCHANGE_ON, i[1], i[0])});
      i_host.hr(i[1], !i[0], q);
      chk(q, {16'h0, lane(w, xv == EXCHANGE_ON, i[1], !i[0])});
    end
    $display("narrow mode tests done");
    n = n_wr;
    i_host.hw(0, 0, 32'h0000beef);
    i_host.hw(0, 0, 32'h0000cafe);
    i_host.hw(0, 1, {16'h0, w[31:16]});
    repeat (2) @(posedge pclk);
    chk(n_wr - n, 32'h0);
    i_host.hw(0, 0, {16'h0, w[15:0]});
    repeat (2) @(posedge pclk);
    chk(last_w, w);
    apb(0, OFS_STATUS, 0);
    chk({24'h0, q[15:8]}, 32'h1);
    n = n_rd;
    i_host.hr(0, 0, q);
    i_host.hr(0, 0, q);
    chk(n_rd - n, 32'h2);
    $display("discard tests done");
    complete_run();
  end
endmodule
